//--- phy_irq_enable_and_tx_control.sv
// Interrupt enable, event status and 100BASE-TX control register bank.
// Assumes datapath events arrive as one-cycle pulses on the same clock,
// and that a classic Wishbone master drives the register bus.

`timescale 1ns/1ns

module phy_irq_enable_and_tx_control (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [7:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire phy_regs_pkg::phy_events_s events_i,
   input  wire logic                      rx_error_evt_i,
   input  wire logic                      autoneg_done_i,
   input  wire logic [2:0]                current_link_mode_i,
   output phy_regs_pkg::phy_ctrl_s        ctrl_o,
   output logic                           irq_o
);
   import phy_regs_pkg::*;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------

   // Merges write data into a 16-bit register by byte lane and mask.
   function automatic logic [15:0] merge16(
      input logic [15:0] old_val,
      input logic [15:0] new_val,
      input logic [1:0]  sel,
      input logic [15:0] mask
   );
      logic [15:0] lanes;
      lanes = {{8{sel[1]}}, {8{sel[0]}}} & mask;
      merge16 = (old_val & ~lanes) | (new_val & lanes);
   endfunction

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic [15:0] enable_reg;
   logic [15:0] control_reg;
   logic [5:0]  events_reg;
   logic [5:0]  events_next;
   logic        rx_full_reg;
   logic        rx_full_next;
   logic [6:0]  rx_cnt_reg;
   logic [6:0]  rx_cnt_next;
   logic        irq_reg;

   logic        take;
   logic        wr_take;
   logic        rd_take;
   logic        hit_status;
   logic        hit_enable;
   logic        hit_control;
   logic        status_read;
   logic        rx_inc;
   logic        rx_reach;
   logic [15:0] status_view;
   logic [15:0] control_view;

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------

   // A request is taken in the cycle before the acknowledge rises.
   assign take        = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_take     = take & wb_we_i;
   assign rd_take     = take & ~wb_we_i;
   assign hit_status  = wb_adr_i[7:2] == PHY_EVENT_STATUS_OFF[7:2];
   assign hit_enable  = wb_adr_i[7:2] == PHY_INTERRUPT_ENABLE_OFF[7:2];
   assign hit_control = wb_adr_i[7:2] == PHY_100TX_CONTROL_OFF[7:2];
   assign status_read = rd_take & hit_status;

   // -------------------------------------------------------------------
   // Read views
   // -------------------------------------------------------------------
   always_comb begin
      status_view = 16'h0000;
      status_view[AUTONEG_DONE_BIT:PAGE_RECEIVED_BIT] = events_reg;
      status_view[RX_ERROR_FULL_BIT] = rx_full_reg;
   end

   always_comb begin
      control_view = control_reg & CONTROL_WRITE_MASK;
      control_view[AUTONEG_DONE_MIRROR_BIT] = autoneg_done_i;
      control_view[CURRENT_LINK_MODE_LSB +: 3] =
         current_link_mode_i;
   end

   // -------------------------------------------------------------------
   // Wishbone acknowledge and read data
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= take;
      end
   end

   // Unmapped offsets and writes return zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_take) begin
         if (hit_status) begin
            rdata_reg <= {16'h0000, status_view};
         end else if (hit_enable) begin
            rdata_reg <= {16'h0000, enable_reg & ENABLE_WRITE_MASK};
         end else if (hit_control) begin
            rdata_reg <= {16'h0000, control_view};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end else if (take) begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // -------------------------------------------------------------------
   // Interrupt enable register
   // -------------------------------------------------------------------

   // Each enable bit sits at the same position as the flag it gates.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_reg <= ENABLE_RESET;
      end else if (wr_take && hit_enable) begin
         enable_reg <= merge16(enable_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                               ENABLE_WRITE_MASK);
      end
   end

   // -------------------------------------------------------------------
   // 100BASE-TX control register
   // -------------------------------------------------------------------

   // Only the writable control bits are stored; status fields are live.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_reg <= CONTROL_RESET;
      end else if (wr_take && hit_control) begin
         control_reg <= merge16(control_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                                CONTROL_WRITE_MASK);
      end
   end

   // Remote loop-back relies on software keeping MAC loop-back at 00.
   assign ctrl_o.rx_error_counter_off =
      control_reg[RX_ERROR_COUNTER_OFF_BIT];
   assign ctrl_o.remote_loopback_on =
      control_reg[REMOTE_LOOPBACK_ON_BIT];
   assign ctrl_o.dc_restore_on =
      control_reg[DC_RESTORE_ON_BIT];
   assign ctrl_o.line_code_convert_on =
      control_reg[LINE_CODE_CONVERT_ON_BIT];
   assign ctrl_o.transmit_isolate =
      control_reg[TRANSMIT_ISOLATE_BIT];
   assign ctrl_o.three_level_coder_bypass =
      control_reg[THREE_LEVEL_CODER_BYPASS_BIT];
   assign ctrl_o.scrambler_off =
      control_reg[SCRAMBLER_OFF_BIT];

   // -------------------------------------------------------------------
   // Latched event flags
   // -------------------------------------------------------------------

   // A read clears the flags it returned; a new event in that cycle wins.
   always_comb begin
      events_next = events_reg;
      if (status_read) begin
         events_next = EVENTS_RESET;
      end
      events_next = events_next | events_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         events_reg <= EVENTS_RESET;
      end else begin
         events_reg <= events_next;
      end
   end

   // -------------------------------------------------------------------
   // Receive-error counter and full flag
   // -------------------------------------------------------------------

   // The counter holds at the threshold so the flag cannot be re-raised
   // by a wrap; a status read restarts the count unless an error arrives
   // in that cycle, which leaves the old count plus one.
   assign rx_inc = rx_error_evt_i
                 & ~control_reg[RX_ERROR_COUNTER_OFF_BIT]
                 & (rx_cnt_reg != RX_ERROR_FULL_COUNT);
   assign rx_reach = rx_inc
                   & (rx_cnt_reg == RX_ERROR_FULL_COUNT - 7'h01);

   always_comb begin
      rx_cnt_next  = rx_cnt_reg;
      rx_full_next = rx_full_reg;
      if (status_read) begin
         rx_cnt_next  = RX_ERROR_CNT_RESET;
         rx_full_next = 1'b0;
      end
      if (rx_inc) begin
         rx_cnt_next = rx_cnt_reg + 7'h01;
      end
      if (rx_reach) begin
         rx_full_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_cnt_reg <= RX_ERROR_CNT_RESET;
      end else begin
         rx_cnt_reg <= rx_cnt_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_full_reg <= 1'b0;
      end else begin
         rx_full_reg <= rx_full_next;
      end
   end

   // -------------------------------------------------------------------
   // Interrupt request
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |({events_reg, rx_full_reg}
                      & enable_reg[AUTONEG_DONE_BIT:RX_ERROR_FULL_BIT]);
      end
   end

   assign irq_o = irq_reg;

endmodule

//--- phy_regs_pkg.sv
// Constants, field layouts and carrier types of the transceiver register bank.
// Assumes a 32-bit classic Wishbone slave and one 20 MHz controller clock.

package phy_regs_pkg;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] PHY_EVENT_STATUS_OFF     = 8'hD4;
   localparam logic [7:0] PHY_INTERRUPT_ENABLE_OFF = 8'hD8;
   localparam logic [7:0] PHY_100TX_CONTROL_OFF    = 8'hDC;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int AUTONEG_DONE_BIT          = 6;
   localparam int REMOTE_FAULT_BIT          = 5;
   localparam int LINK_DOWN_BIT             = 4;
   localparam int PARTNER_ACK_BIT           = 3;
   localparam int PARALLEL_DETECT_FAULT_BIT = 2;
   localparam int PAGE_RECEIVED_BIT         = 1;
   localparam int RX_ERROR_FULL_BIT         = 0;

   localparam int RX_ERROR_COUNTER_OFF_BIT     = 13;
   localparam int AUTONEG_DONE_MIRROR_BIT      = 12;
   localparam int REMOTE_LOOPBACK_ON_BIT       = 9;
   localparam int DC_RESTORE_ON_BIT            = 8;
   localparam int LINE_CODE_CONVERT_ON_BIT     = 7;
   localparam int TRANSMIT_ISOLATE_BIT         = 5;
   localparam int CURRENT_LINK_MODE_LSB        = 2;
   localparam int THREE_LEVEL_CODER_BYPASS_BIT = 1;
   localparam int SCRAMBLER_OFF_BIT            = 0;

   // -------------------------------------------------------------------
   // Masks and values after reset
   // -------------------------------------------------------------------
   localparam logic [15:0] ENABLE_WRITE_MASK  = 16'h007F;
   localparam logic [15:0] CONTROL_WRITE_MASK = 16'h23A3;
   localparam logic [15:0] ENABLE_RESET       = 16'h0000;
   localparam logic [15:0] CONTROL_RESET      = 16'h0100;
   localparam logic [5:0]  EVENTS_RESET       = 6'h00;

   // -------------------------------------------------------------------
   // Receive-error counting
   // -------------------------------------------------------------------
   localparam logic [6:0] RX_ERROR_FULL_COUNT = 7'h40;
   localparam logic [6:0] RX_ERROR_CNT_RESET  = 7'h00;

   // -------------------------------------------------------------------
   // Current link mode codes
   // -------------------------------------------------------------------
   localparam logic [2:0] MODE_NEGOTIATING    = 3'h0;
   localparam logic [2:0] MODE_10BT_HALF      = 3'h1;
   localparam logic [2:0] MODE_100TX_HALF     = 3'h2;
   localparam logic [2:0] MODE_10BT_FULL      = 3'h5;
   localparam logic [2:0] MODE_100TX_FULL     = 3'h6;

   // -------------------------------------------------------------------
   // Carrier types
   // -------------------------------------------------------------------
   typedef struct packed {
      logic autoneg_done;
      logic remote_fault;
      logic link_down;
      logic partner_ack;
      logic parallel_detect_fault;
      logic page_received;
   } phy_events_s;

   typedef struct packed {
      logic rx_error_counter_off;
      logic remote_loopback_on;
      logic dc_restore_on;
      logic line_code_convert_on;
      logic transmit_isolate;
      logic three_level_coder_bypass;
      logic scrambler_off;
   } phy_ctrl_s;

endpackage

//--- phy_regs_pkg_end.sv
// Intentionally empty companion: no content.

//--- phy_bank_properties.sv
// Port-level checks of the transceiver interrupt enable and control bank.
// Bound to the bank's top module; sees nothing but its ports.
`timescale 1ns/1ns
module phy_bank_properties (
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_we_i,
   input wire logic [7:0]                wb_adr_i,
   input wire logic [3:0]                wb_sel_i,
   input wire logic [31:0]               wb_dat_i,
   input wire logic [31:0]               wb_dat_o,
   input wire logic                      wb_ack_o,
   input wire phy_regs_pkg::phy_events_s events_i,
   input wire logic                      rx_error_evt_i,
   input wire logic                      autoneg_done_i,
   input wire logic [2:0]                current_link_mode_i,
   input wire phy_regs_pkg::phy_ctrl_s   ctrl_o,
   input wire logic                      irq_o
);
   import phy_regs_pkg::*;
   logic take;
   logic rd_ack;
   logic at_ctl;
   logic at_stat;
   assign take    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd_ack  = wb_ack_o & ~wb_we_i;
   assign at_ctl  = wb_adr_i[7:2] == PHY_100TX_CONTROL_OFF[7:2];
   assign at_stat = wb_adr_i[7:2] == PHY_EVENT_STATUS_OFF[7:2];
   function automatic phy_ctrl_s pick(input logic [15:0] d);
      return {d[13], d[9:7], d[5], d[1:0]};
   endfunction
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   property p_ack_next; take |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_upper; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper data set");
   property p_ctl_resv; rd_ack && at_ctl |-> {wb_dat_o[15:14],
      wb_dat_o[11:10], wb_dat_o[6]} == 5'h00; endproperty
   a_ctl_resv: assert property (p_ctl_resv) else $error("rsv bit");
   property p_live; rd_ack && at_ctl |-> wb_dat_o[12] == $past(autoneg_done_i)
      && wb_dat_o[4:2] == $past(current_link_mode_i); endproperty
   a_live: assert property (p_live) else $error("live bits");
   property p_ctl_read; rd_ack && at_ctl |-> pick(wb_dat_o[15:0]) == ctrl_o;
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("rd bad");
   property p_ctl_write; take && wb_we_i && at_ctl && wb_sel_i[1:0] == 2'h3
      |=> ctrl_o == pick($past(wb_dat_i[15:0])); endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("wr");
   property p_irq_clear; take && !wb_we_i && at_stat && events_i == 6'h00 &&
      !rx_error_evt_i |-> ##2 !irq_o; endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq");
   property p_reset; disable iff (1'b0)
      rst_i |=> !wb_ack_o && !irq_o && ctrl_o == 7'h10; endproperty
   a_reset: assert property (p_reset) else $error("reset");
endmodule

bind phy_irq_enable_and_tx_control phy_bank_properties u_props (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .events_i, .rx_error_evt_i,
   .autoneg_done_i, .current_link_mode_i, .ctrl_o, .irq_o);

//--- phy_datapath_model.sv
// Behavioural stand-in for the transceiver datapath beside the bank.
// Driven by the bench; each request leaves one clock later.
`timescale 1ns/1ns
module phy_datapath_model (
   input  wire logic                 clk_i,
   input  wire logic [6:0]           fire_i,
   input  wire logic [3:0]           level_i,
   output phy_regs_pkg::phy_events_s events_o,
   output logic                      rx_error_evt_o,
   output logic                      autoneg_done_o,
   output logic [2:0]                current_link_mode_o
);
   import phy_regs_pkg::*;
   // Events follow the fire bits for as many cycles as the bench holds them, on the bank's own clock.
   always_ff @(posedge clk_i) begin
      {events_o, rx_error_evt_o} <= fire_i;
   end
   always_ff @(posedge clk_i) begin
      {autoneg_done_o, current_link_mode_o} <= level_i;
   end
endmodule

//--- phy_irq_enable_and_tx_control_test.sv
// Self-checking bench of the transceiver interrupt enable and control bank.
// Drives Wishbone and the datapath model from one 20 MHz clock.
`timescale 1ns/1ns
module phy_irq_enable_and_tx_control_test;
   import phy_regs_pkg::*;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              wb_cyc_i = 1'b0;
   logic              wb_stb_i = 1'b0;
   logic              wb_we_i = 1'b0;
   logic [7:0]        wb_adr_i = 8'h00;
   logic [3:0]        wb_sel_i = 4'h0;
   logic [31:0]       wb_dat_i = 32'h0000_0000;
   logic [31:0]       wb_dat_o;
   logic [31:0]       rd;
   logic              wb_ack_o;
   logic              rx_error_evt_i;
   logic              autoneg_done_i;
   logic              irq_o;
   logic [2:0]        current_link_mode_i;
   logic [6:0]        fire = 7'h00;
   logic [3:0]        level = 4'h0;
   logic [3:0]        s;
   logic [15:0]       lfsr = 16'h0038;
   logic [15:0]       d;
   logic [31:0]       x;
   logic [15:0]       ctl = 16'h0100;
   logic [15:0]       en = 16'h0000;
   logic [2:0]        modes [5] = '{MODE_NEGOTIATING, MODE_10BT_HALF,
      MODE_100TX_HALF, MODE_10BT_FULL, MODE_100TX_FULL};
   phy_events_s       events_i;
   phy_ctrl_s         ctrl_o;
   int                mismatches = 0;
   int                comparisons = 0;
   int                cycles = 0;

   always #25 clk_i = ~clk_i;

   phy_irq_enable_and_tx_control DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .events_i, .rx_error_evt_i, .autoneg_done_i, .current_link_mode_i,
      .ctrl_o, .irq_o);
   phy_datapath_model u_far (.clk_i, .fire_i(fire), .level_i(level),
      .events_o(events_i), .rx_error_evt_o(rx_error_evt_i),
      .autoneg_done_o(autoneg_done_i),
      .current_link_mode_o(current_link_mode_i));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [15:0] next_rand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [15:0] merge(input logic [15:0] o, n, m,
                                         input logic [1:0] sl);
      logic [15:0] lanes;
      lanes = {{8{sl[1]}}, {8{sl[0]}}} & m;
      return (o & ~lanes) | (n & lanes);
   endfunction
   task automatic check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [15:0] v, input logic [3:0] sl);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= sl;
      wb_dat_i <= {16'h0000, v};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic pulse(input logic [6:0] v, input int n);
      repeat (n) begin
         fire <= v;
         @(posedge clk_i);
      end
      fire <= 7'h00;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic final_report();
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({25'h0, ctrl_o}, 32'h0000_0010);
      wb(1'b0, PHY_INTERRUPT_ENABLE_OFF, 16'h0000, 4'hF);
      check(rd, 32'h0000_0000);
      wb(1'b1, 8'hE0, 16'hFFFF, 4'hF);
      wb(1'b0, 8'hE0, 16'h0000, 4'hF);
      check(rd, 32'h0000_0000);
      for (int i = 0; i < 10; i++) begin
         lfsr = next_rand(lfsr);
         d = lfsr;
         s = (d[9:8] == 2'h0) ? 4'h3 : {2'h0, d[9:8]};
         level <= {d[3], modes[int'(d[6:4]) % 5]};
         wb(1'b1, PHY_100TX_CONTROL_OFF, d, s);
         ctl = merge(ctl, d, CONTROL_WRITE_MASK, s[1:0]);
         x = {25'h0, ctl[13], ctl[9:7], ctl[5], ctl[1:0]};
         check({25'h0, ctrl_o}, x);
         wb(1'b0, PHY_100TX_CONTROL_OFF, 16'h0000, 4'hF);
         x = {16'h0000, ctl | {3'h0, level[3], 7'h00, level[2:0], 2'h0}};
         check(rd, x);
         wb(1'b1, PHY_INTERRUPT_ENABLE_OFF, ~d, s);
         en = merge(en, ~d, ENABLE_WRITE_MASK, s[1:0]);
         wb(1'b0, PHY_INTERRUPT_ENABLE_OFF, 16'h0000, 4'hF);
         check(rd, {16'h0, en});
      end
      for (int b = 1; b < 7; b++) begin
         wb(1'b1, PHY_INTERRUPT_ENABLE_OFF, 16'h0001 << b, 4'h3);
         pulse(7'h01 << b, 1);
         check({31'h0, irq_o}, 32'h1);
         wb(1'b0, PHY_EVENT_STATUS_OFF, 16'h0000, 4'h3);
         check(rd, 32'h1 << b);
         check({31'h0, irq_o}, 32'h0);
         wb(1'b1, PHY_INTERRUPT_ENABLE_OFF, 16'h007F ^ (16'h1 << b), 4'h3);
         pulse(7'h01 << b, 1);
         check({31'h0, irq_o}, 32'h0);
         wb(1'b0, PHY_EVENT_STATUS_OFF, 16'h0000, 4'h3);
         check(rd, 32'h1 << b);
      end
      wb(1'b1, PHY_100TX_CONTROL_OFF, 16'h0100, 4'h3);
      wb(1'b1, PHY_INTERRUPT_ENABLE_OFF, 16'h0001, 4'h3);
      pulse(7'h01, 63);
      check({31'h0, irq_o}, 32'h0);
      pulse(7'h01, 1);
      check({31'h0, irq_o}, 32'h1);
      pulse(7'h01, 70);
      wb(1'b0, PHY_EVENT_STATUS_OFF, 16'h0000, 4'h3);
      check(rd, 32'h0000_0001);
      wb(1'b1, PHY_100TX_CONTROL_OFF, 16'h2100, 4'h3);
      pulse(7'h01, 64);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b0, PHY_EVENT_STATUS_OFF, 16'h0000, 4'h3);
      check(rd, 32'h0000_0000);
      final_report();
   end
endmodule
